// ==== hw/adcie_pkg.sv ====
package adcie_pkg;
	// Channel and data sizes
	localparam int          ADCIE_NCHAN        = 12;
	localparam int          ADCIE_CHAN_W       = 4;
	localparam int          ADCIE_RES_W        = 12;
	localparam int          ADCIE_DATA_W       = 32;
	// Register byte addresses on the APB side
	localparam logic [31:0] ADCIE_ENABLE_ADDR  = 32'h4001c064;
	localparam logic [31:0] ADCIE_FLAG_ADDR    = 32'h4001c068;
	localparam logic [31:0] ADCIE_STATUS_ADDR  = 32'h4001c070;
	localparam logic [31:0] ADCIE_MASK_ADDR    = 32'h4001c074;
	// Enable register layout
	localparam int          ADCIE_SEQA_EN_BIT  = 0;
	localparam int          ADCIE_SEQB_EN_BIT  = 1;
	localparam int          ADCIE_OVR_EN_BIT   = 2;
	localparam int          ADCIE_THR_LSB      = 3;
	localparam int          ADCIE_THR_W        = 2;
	localparam int          ADCIE_ENABLE_MSB   = 26;
	localparam logic [31:0] ADCIE_ENABLE_RST   = 32'h0000_0000;
	// Threshold interrupt field codes
	localparam logic [1:0]  ADCIE_THR_DISABLED = 2'h0;
	localparam logic [1:0]  ADCIE_THR_OUTSIDE  = 2'h1;
	localparam logic [1:0]  ADCIE_THR_CROSSING = 2'h2;
	localparam logic [1:0]  ADCIE_THR_RESERVED = 2'h3;
	// Interrupt status and mask layout
	localparam int          ADCIE_ST_W         = 4;
	localparam int          ADCIE_ST_SEQA      = 0;
	localparam int          ADCIE_ST_SEQB      = 1;
	localparam int          ADCIE_ST_OVR       = 2;
	localparam int          ADCIE_ST_THR       = 3;
	localparam logic [3:0]  ADCIE_STATUS_RST   = 4'h0;
	localparam logic [3:0]  ADCIE_MASK_RST     = 4'h0;
	localparam logic [11:0] ADCIE_FLAG_RST     = 12'h000;
endpackage : adcie_pkg

// ==== hw/adcie_cmp_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface adcie_cmp_if;
	import adcie_pkg::*;
	logic                    req_valid;
	logic [ADCIE_CHAN_W-1:0] req_chan;
	logic [ADCIE_RES_W-1:0]  req_result;
	logic [ADCIE_RES_W-1:0]  req_low;
	logic [ADCIE_RES_W-1:0]  req_high;
	logic [1:0]              req_mode;
	logic                    hit;
	logic [ADCIE_CHAN_W-1:0] hit_chan;
	// Issuing side hands a result over, comparator answers one cycle later
	modport issuer (output req_valid, req_chan, req_result, req_low, req_high, req_mode,
		input hit, hit_chan);
	modport cmp (input req_valid, req_chan, req_result, req_low, req_high, req_mode,
		output hit, hit_chan);
endinterface : adcie_cmp_if
`default_nettype wire

// ==== hw/adcie_chan_cmp.sv ====
`timescale 1ns/1ns
`default_nettype none
module adcie_chan_cmp
	import adcie_pkg::*;
(
	input  wire logic  ref_clk,
	input  wire logic  rst,
	input  wire logic  ce,
	adcie_cmp_if.cmp   cmp
);
	logic [ADCIE_NCHAN-1:0]  below_r;
	logic [ADCIE_NCHAN-1:0]  below_nxt;
	logic [ADCIE_NCHAN-1:0]  seen_r;
	logic [ADCIE_NCHAN-1:0]  seen_nxt;
	logic                    hit_r;
	logic                    hit_nxt;
	logic [ADCIE_CHAN_W-1:0] hit_chan_r;
	logic [ADCIE_CHAN_W-1:0] hit_chan_nxt;
	logic                    below_now;
	logic                    outside_now;

	// Side history is kept in every mode, so switching to crossing mode needs no warm-up
	always_comb begin
		below_nxt    = below_r;
		seen_nxt     = seen_r;
		hit_nxt      = 1'b0;
		hit_chan_nxt = hit_chan_r;
		below_now    = cmp.req_result < cmp.req_low;
		outside_now  = below_now || (cmp.req_result > cmp.req_high);
		if (cmp.req_valid) begin
			hit_chan_nxt = cmp.req_chan;
			unique case (cmp.req_mode)
				ADCIE_THR_OUTSIDE:  hit_nxt = outside_now;
				ADCIE_THR_CROSSING: hit_nxt = seen_r[cmp.req_chan] &&
					(below_r[cmp.req_chan] != below_now);
				ADCIE_THR_DISABLED: hit_nxt = 1'b0;
				ADCIE_THR_RESERVED: hit_nxt = 1'b0;
			endcase
			below_nxt[cmp.req_chan] = below_now;
			seen_nxt[cmp.req_chan]  = 1'b1;
		end
	end

	// Registered answer
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			below_r    <= '0;
			seen_r     <= '0;
			hit_r      <= 1'b0;
			hit_chan_r <= '0;
		end else if (ce) begin
			below_r    <= below_nxt;
			seen_r     <= seen_nxt;
			hit_r      <= hit_nxt;
			hit_chan_r <= hit_chan_nxt;
		end
	end

	assign cmp.hit      = hit_r;
	assign cmp.hit_chan = hit_chan_r;
endmodule : adcie_chan_cmp
`default_nettype wire

// ==== hw/adcie_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module adcie_top
	import adcie_pkg::*;
#(
	parameter int NCHAN = ADCIE_NCHAN
)(
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	input  wire logic                    ce,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    conv_valid,
	input  wire logic [ADCIE_CHAN_W-1:0] conv_chan,
	input  wire logic [ADCIE_RES_W-1:0]  conv_result,
	input  wire logic [NCHAN-1:0]        chan_threshold_pair_select,
	input  wire logic [ADCIE_RES_W-1:0]  threshold_pair0_low,
	input  wire logic [ADCIE_RES_W-1:0]  threshold_pair0_high,
	input  wire logic [ADCIE_RES_W-1:0]  threshold_pair1_low,
	input  wire logic [ADCIE_RES_W-1:0]  threshold_pair1_high,
	input  wire logic                    seq_a_mode,
	input  wire logic                    seq_b_mode,
	input  wire logic                    seq_a_conv_done,
	input  wire logic                    seq_a_seq_done,
	input  wire logic                    seq_b_conv_done,
	input  wire logic                    seq_b_seq_done,
	input  wire logic [NCHAN-1:0]        chan_overrun,
	input  wire logic                    seq_a_gdat_overrun,
	input  wire logic                    seq_b_gdat_overrun,
	output logic                         seq_a_trig,
	output logic                         seq_b_trig,
	output logic                         overrun_req,
	output logic                         thresh_req,
	output logic      [NCHAN-1:0]        chan_thresh_event_flag,
	output logic                         irq
);
	adcie_cmp_if cmp_bus ();

	// APB slave state
	logic [31:0]           prdata_r;
	logic [31:0]           prdata_nxt;
	logic                  pslverr_r;
	logic                  pslverr_nxt;
	logic                  cap_r;
	logic                  cap_nxt;
	logic                  hit_enable;
	logic                  hit_flag;
	logic                  hit_status;
	logic                  hit_mask;
	logic                  addr_ok;
	logic                  access;
	logic                  wr_access;
	logic                  rd_access;
	logic [31:0]           byte_mask;

	// Register file state
	logic [31:0]           adc_irq_enable_r;
	logic [31:0]           adc_irq_enable_nxt;
	logic [NCHAN-1:0]      flag_r;
	logic [NCHAN-1:0]      flag_nxt;
	logic [ADCIE_ST_W-1:0] status_r;
	logic [ADCIE_ST_W-1:0] status_nxt;
	logic [ADCIE_ST_W-1:0] mask_r;
	logic [ADCIE_ST_W-1:0] mask_nxt;
	logic [ADCIE_ST_W-1:0] status_ev;
	logic [ADCIE_ST_W-1:0] status_clr;

	// Request outputs
	logic                  seq_a_trig_r;
	logic                  seq_a_trig_nxt;
	logic                  seq_b_trig_r;
	logic                  seq_b_trig_nxt;
	logic                  overrun_req_r;
	logic                  overrun_req_nxt;
	logic                  thresh_req_r;
	logic                  thresh_req_nxt;
	logic                  irq_r;
	logic                  irq_nxt;

	// Comparator request side
	logic                  chan_ok;
	logic                  pair_sel;
	logic [NCHAN-1:0]      chan_active;
	logic [NCHAN-1:0]      flag_set;
	logic [NCHAN-1:0]      flag_wclr;

	// Address decode; unmapped addresses answer with an error and read as zero
	always_comb begin
		hit_enable = paddr == ADCIE_ENABLE_ADDR;
		hit_flag   = paddr == ADCIE_FLAG_ADDR;
		hit_status = paddr == ADCIE_STATUS_ADDR;
		hit_mask   = paddr == ADCIE_MASK_ADDR;
		addr_ok    = hit_enable || hit_flag || hit_status || hit_mask;
		access     = psel && penable && ce && cap_r;
		wr_access  = access && pwrite && addr_ok;
		rd_access  = access && !pwrite && addr_ok;
		byte_mask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	end

	// Read data is captured one cycle ahead so prdata comes straight from a flop
	always_comb begin
		prdata_nxt  = prdata_r;
		pslverr_nxt = pslverr_r;
		cap_nxt     = cap_r;
		if (psel && !access) begin
			prdata_nxt  = '0;
			pslverr_nxt = !addr_ok;
			cap_nxt     = 1'b1;
			if (hit_enable) begin
				prdata_nxt[ADCIE_ENABLE_MSB:0] = adc_irq_enable_r[ADCIE_ENABLE_MSB:0];
			end
			if (hit_flag) begin
				prdata_nxt[NCHAN-1:0] = flag_r;
			end
			if (hit_status) begin
				prdata_nxt[ADCIE_ST_W-1:0] = status_r;
			end
			if (hit_mask) begin
				prdata_nxt[ADCIE_ST_W-1:0] = mask_r;
			end
		end else if (access || !psel) begin
			cap_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prdata_r  <= '0;
			pslverr_r <= 1'b0;
			cap_r     <= 1'b0;
		end else if (ce) begin
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			cap_r     <= cap_nxt;
		end
	end

	// Ready only once the read word has been captured for this transfer
	assign pready  = psel && penable && ce && cap_r;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r && pready;

	// Enable register; reserved bits 31:27 are never stored and read zero
	always_comb begin
		adc_irq_enable_nxt = adc_irq_enable_r;
		if (wr_access && hit_enable) begin
			adc_irq_enable_nxt = (adc_irq_enable_r & ~byte_mask) | (pwdata & byte_mask);
			adc_irq_enable_nxt[31:ADCIE_ENABLE_MSB+1] = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			adc_irq_enable_r <= ADCIE_ENABLE_RST;
		end else if (ce) begin
			adc_irq_enable_r <= adc_irq_enable_nxt;
		end
	end

	// Hand each conversion on a channel below NCHAN to the comparator with its selected threshold pair
	always_comb begin
		chan_ok  = conv_chan < ADCIE_CHAN_W'(NCHAN);
		pair_sel = chan_ok ? chan_threshold_pair_select[conv_chan] : 1'b0;
		cmp_bus.req_valid  = conv_valid && chan_ok;
		cmp_bus.req_chan   = conv_chan;
		cmp_bus.req_result = conv_result;
		cmp_bus.req_low    = pair_sel ? threshold_pair1_low : threshold_pair0_low;
		cmp_bus.req_high   = pair_sel ? threshold_pair1_high : threshold_pair0_high;
		cmp_bus.req_mode   = chan_ok ?
			adc_irq_enable_r[ADCIE_THR_LSB + ADCIE_THR_W*conv_chan +: ADCIE_THR_W] :
			ADCIE_THR_DISABLED;
	end

	adcie_chan_cmp u_cmp (
		.ref_clk (ref_clk),
		.rst     (rst),
		.ce      (ce),
		.cmp     (cmp_bus.cmp)
	);

	// Per-channel flags: a new event in the clearing cycle survives the clear
	genvar gi;
	generate
		for (gi = 0; gi < NCHAN; gi++) begin : g_chan
			localparam int FLSB = ADCIE_THR_LSB + ADCIE_THR_W*gi;
			logic [1:0] mode_f;
			assign mode_f          = adc_irq_enable_r[FLSB +: ADCIE_THR_W];
			assign chan_active[gi] = (mode_f == ADCIE_THR_OUTSIDE) ||
				(mode_f == ADCIE_THR_CROSSING);
			assign flag_set[gi]    = cmp_bus.hit &&
				(cmp_bus.hit_chan == ADCIE_CHAN_W'(gi));
			assign flag_wclr[gi]   = wr_access && hit_flag && pwdata[gi] &&
				pstrb[gi/8];
			assign flag_nxt[gi]    = flag_set[gi] || (flag_r[gi] && !flag_wclr[gi]);
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flag_r <= ADCIE_FLAG_RST;
		end else if (ce) begin
			flag_r <= flag_nxt;
		end
	end

	// Gated requests toward interrupt and DMA controllers
	always_comb begin
		seq_a_trig_nxt  = adc_irq_enable_r[ADCIE_SEQA_EN_BIT] &&
			(seq_a_mode ? seq_a_seq_done : seq_a_conv_done);
		seq_b_trig_nxt  = adc_irq_enable_r[ADCIE_SEQB_EN_BIT] &&
			(seq_b_mode ? seq_b_seq_done : seq_b_conv_done);
		overrun_req_nxt = adc_irq_enable_r[ADCIE_OVR_EN_BIT] &&
			((|chan_overrun) ||
			(seq_a_gdat_overrun && !seq_a_mode) ||
			(seq_b_gdat_overrun && !seq_b_mode));
		// A flag whose field was later disabled stops requesting at once
		thresh_req_nxt  = |(flag_nxt & chan_active);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seq_a_trig_r  <= 1'b0;
			seq_b_trig_r  <= 1'b0;
			overrun_req_r <= 1'b0;
			thresh_req_r  <= 1'b0;
		end else if (ce) begin
			seq_a_trig_r  <= seq_a_trig_nxt;
			seq_b_trig_r  <= seq_b_trig_nxt;
			overrun_req_r <= overrun_req_nxt;
			thresh_req_r  <= thresh_req_nxt;
		end
	end

	// Sticky status; a read clears only the bits it returned, so late events stay
	always_comb begin
		status_ev                = '0;
		status_ev[ADCIE_ST_SEQA] = seq_a_trig_nxt;
		status_ev[ADCIE_ST_SEQB] = seq_b_trig_nxt;
		status_ev[ADCIE_ST_OVR]  = overrun_req_nxt;
		status_ev[ADCIE_ST_THR]  = |(flag_set & chan_active);
		status_clr = (rd_access && hit_status) ? prdata_r[ADCIE_ST_W-1:0] : '0;
		status_nxt = (status_r & ~status_clr) | status_ev;
		mask_nxt   = mask_r;
		if (wr_access && hit_mask && pstrb[0]) begin
			mask_nxt = pwdata[ADCIE_ST_W-1:0];
		end
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status_r <= ADCIE_STATUS_RST;
			mask_r   <= ADCIE_MASK_RST;
			irq_r    <= 1'b0;
		end else if (ce) begin
			status_r <= status_nxt;
			mask_r   <= mask_nxt;
			irq_r    <= irq_nxt;
		end
	end

	// Request, flag and irq outputs all come from flops
	assign seq_a_trig             = seq_a_trig_r;
	assign seq_b_trig             = seq_b_trig_r;
	assign overrun_req            = overrun_req_r;
	assign thresh_req             = thresh_req_r;
	assign chan_thresh_event_flag = flag_r;
	assign irq                    = irq_r;
endmodule : adcie_top
`default_nettype wire

// ==== dv/adcie_top_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module adcie_top_monitor
	import adcie_pkg::*;
#(
	parameter int NCHAN = ADCIE_NCHAN
)(
	input wire logic             ref_clk,
	input wire logic             rst,
	input wire logic             ce,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic             conv_valid,
	input wire logic             seq_a_mode,
	input wire logic             seq_b_mode,
	input wire logic             seq_a_conv_done,
	input wire logic             seq_a_seq_done,
	input wire logic             seq_b_conv_done,
	input wire logic             seq_b_seq_done,
	input wire logic [NCHAN-1:0] chan_overrun,
	input wire logic             seq_a_gdat_overrun,
	input wire logic             seq_b_gdat_overrun,
	input wire logic             seq_a_trig,
	input wire logic             seq_b_trig,
	input wire logic             overrun_req,
	input wire logic             thresh_req,
	input wire logic [NCHAN-1:0] chan_thresh_event_flag,
	input wire logic             irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Access phase with the clock running
	sequence s_access;
		psel && penable && ce;
	endsequence
	// A flag rising without a conversion two cycles back means a phantom hit
	sequence s_flag_rise;
		|(chan_thresh_event_flag & ~$past(chan_thresh_event_flag));
	endsequence
	a_ready_nowait: assert property (s_access |-> pready)
		else $error("pready missing in access phase");
	a_err_in_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside ready");
	a_seqa_cause: assert property (seq_a_trig |-> ($past(seq_a_mode) ?
		$past(seq_a_seq_done) : $past(seq_a_conv_done))) else $error("seq a trigger without cause");
	a_seqb_cause: assert property (seq_b_trig |-> ($past(seq_b_mode) ?
		$past(seq_b_seq_done) : $past(seq_b_conv_done))) else $error("seq b trigger without cause");
	a_ovr_cause: assert property (overrun_req |-> (|$past(chan_overrun)) ||
		($past(seq_a_gdat_overrun) && !$past(seq_a_mode)) ||
		($past(seq_b_gdat_overrun) && !$past(seq_b_mode))) else $error("overrun without cause");
	a_thr_has_flag: assert property (thresh_req |-> |chan_thresh_event_flag)
		else $error("threshold request with no flag");
	a_flag_from_conv: assert property (s_flag_rise |-> $past(conv_valid, 2))
		else $error("flag set without conversion");
	a_reset_quiet: assert property ($past(rst) |-> !seq_a_trig && !seq_b_trig &&
		!overrun_req && !thresh_req && !irq && chan_thresh_event_flag == '0)
		else $error("outputs not clear after reset");
endmodule : adcie_top_monitor
bind adcie_top adcie_top_monitor #(.NCHAN(NCHAN)) u_mon (.ref_clk, .rst, .ce, .psel, .penable,
	.pready, .pslverr, .conv_valid, .seq_a_mode, .seq_b_mode, .seq_a_conv_done, .seq_a_seq_done,
	.seq_b_conv_done, .seq_b_seq_done, .chan_overrun, .seq_a_gdat_overrun, .seq_b_gdat_overrun,
	.seq_a_trig, .seq_b_trig, .overrun_req, .thresh_req, .chan_thresh_event_flag, .irq);
`default_nettype wire

// ==== dv/adcie_irq_sink.sv ====
`timescale 1ns/1ns
`default_nettype none
module adcie_irq_sink (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic seq_a_trig,
	input  wire logic seq_b_trig,
	input  wire logic overrun_req,
	output var  int   n_a,
	output var  int   n_b,
	output var  int   n_ovr
);
	// DMA side takes one transfer per pulse, so a doubled or lost pulse shows in the counts
	always @(posedge ref_clk) begin
		if (rst) begin
			n_a <= 0;
			n_b <= 0;
			n_ovr <= 0;
		end else begin
			n_a <= n_a + int'(seq_a_trig);
			n_b <= n_b + int'(seq_b_trig);
			n_ovr <= n_ovr + int'(overrun_req);
		end
	end
endmodule : adcie_irq_sink
`default_nettype wire

// ==== dv/tb_adcie_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_adcie_top;
	import adcie_pkg::*;
	logic        ref_clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
	logic [3:0]  pstrb = 4'hf, conv_chan = '0;
	logic        pready, pslverr, er, conv_valid = 0, seq_a_mode = 0, seq_b_mode = 0;
	logic [11:0] conv_result = '0, chan_threshold_pair_select = '0, chan_overrun = '0;
	logic [11:0] threshold_pair0_low = '0, threshold_pair0_high = '0;
	logic [11:0] threshold_pair1_low = '0, threshold_pair1_high = '0;
	logic        seq_a_conv_done = 0, seq_a_seq_done = 0, seq_b_conv_done = 0, seq_b_seq_done = 0;
	logic        seq_a_gdat_overrun = 0, seq_b_gdat_overrun = 0;
	logic        seq_a_trig, seq_b_trig, overrun_req, thresh_req, irq;
	logic [11:0] chan_thresh_event_flag;
	int          fails = 0, n_tests = 0, cyc = 0, n_a, n_b, n_ovr;
	always #20 ref_clk = ~ref_clk;
	adcie_top #(.NCHAN(12)) DUT (.ref_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .conv_valid, .conv_chan, .conv_result,
		.chan_threshold_pair_select, .threshold_pair0_low, .threshold_pair0_high,
		.threshold_pair1_low, .threshold_pair1_high, .seq_a_mode, .seq_b_mode, .seq_a_conv_done,
		.seq_a_seq_done, .seq_b_conv_done, .seq_b_seq_done, .chan_overrun, .seq_a_gdat_overrun,
		.seq_b_gdat_overrun, .seq_a_trig, .seq_b_trig, .overrun_req, .thresh_req,
		.chan_thresh_event_flag, .irq);
	adcie_irq_sink u_sink (.ref_clk, .rst, .seq_a_trig, .seq_b_trig, .overrun_req, .n_a, .n_b,
		.n_ovr);
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	// Data is taken at the rising edge where pready is seen high, then the request drops
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// One result in, flags settle two cycles later
	task conv(input logic [3:0] c, input logic [11:0] r);
		@(posedge ref_clk);
		conv_valid <= 1'b1;
		conv_chan <= c;
		conv_result <= r;
		@(posedge ref_clk);
		conv_valid <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask : conv
	task t_regs;
		apb(0, ADCIE_ENABLE_ADDR, 0);
		check(rd, 32'h0);
		apb(0, 32'h4001c0fc, 0);
		check(rd, 32'h0);
		check(er, 1'b1);
		apb(1, ADCIE_ENABLE_ADDR, 32'hf800_0007);
		apb(0, ADCIE_ENABLE_ADDR, 0);
		check(rd, 32'h7);
	endtask : t_regs
	// Every enable, mode and cause pairing; only the matching kind of done fires
	task t_seq;
		for (int i = 0; i < 8; i++) begin
			apb(1, ADCIE_ENABLE_ADDR, {30'h0, i[2], i[2]});
			seq_a_mode <= i[1];
			seq_b_mode <= i[1];
			@(posedge ref_clk);
			{seq_a_conv_done, seq_a_seq_done, seq_b_conv_done, seq_b_seq_done} <= {2{!i[0], i[0]}};
			@(posedge ref_clk);
			{seq_a_conv_done, seq_a_seq_done, seq_b_conv_done, seq_b_seq_done} <= 4'h0;
			@(negedge ref_clk);
			check(seq_a_trig, i[2] && (i[1] == i[0]));
			check(seq_b_trig, i[2] && (i[1] == i[0]));
		end
		// Let the sink count the last pulse before looking at its totals
		@(posedge ref_clk);
		@(negedge ref_clk);
		check(n_a, 2);
		check(n_b, 2);
	endtask : t_seq
	// Channel register, then each global register under both modes
	task t_ovr;
		for (int i = 0; i < 12; i++) begin
			apb(1, ADCIE_ENABLE_ADDR, {29'h0, i[0], 2'h0});
			seq_a_mode <= i[1];
			seq_b_mode <= i[1];
			@(posedge ref_clk);
			chan_overrun <= (i / 4 == 0) ? 12'h800 : 12'h000;
			seq_a_gdat_overrun <= (i / 4 == 1);
			seq_b_gdat_overrun <= (i / 4 == 2);
			@(posedge ref_clk);
			{chan_overrun, seq_a_gdat_overrun, seq_b_gdat_overrun} <= '0;
			@(negedge ref_clk);
			check(overrun_req, i[0] && (i / 4 == 0 || !i[1]));
		end
	endtask : t_ovr
	task t_thr;
		threshold_pair0_low <= 12'h064;
		threshold_pair0_high <= 12'h0c8;
		threshold_pair1_low <= 12'h3e8;
		threshold_pair1_high <= 12'h7d0;
		chan_threshold_pair_select <= 12'h800;
		apb(0, ADCIE_STATUS_ADDR, 0);
		apb(1, ADCIE_MASK_ADDR, 32'h8);
		apb(1, ADCIE_ENABLE_ADDR, 32'h0240_0000);
		conv(4'h0, 12'h032);
		check(chan_thresh_event_flag, 12'h000);
		check(irq, 1'b0);
		conv(4'hb, 12'h1f4);
		check(chan_thresh_event_flag, 12'h800);
		check({thresh_req, irq}, 2'h3);
		conv(4'h9, 12'h032);
		check(chan_thresh_event_flag, 12'h800);
		conv(4'h9, 12'h096);
		check(chan_thresh_event_flag, 12'ha00);
		apb(0, ADCIE_STATUS_ADDR, 0);
		check(rd, 32'h8);
		@(posedge ref_clk);
		@(negedge ref_clk);
		check(irq, 1'b0);
		apb(1, ADCIE_FLAG_ADDR, 32'h800);
		apb(0, ADCIE_FLAG_ADDR, 0);
		check(rd, 32'h200);
		apb(1, ADCIE_ENABLE_ADDR, 0);
		@(posedge ref_clk);
		@(negedge ref_clk);
		check(thresh_req, 1'b0);
	endtask : t_thr
	// Whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs();
		t_seq();
		t_ovr();
		t_thr();
		tally_and_finish();
	end
endmodule : tb_adcie_top
`default_nettype wire
